//--- hw/twe_port.sv
/*
  Serial port and array of a 64 x 16 nonvolatile memory, with a command queue.
  Assumes select, serial clock and serial input arrive asynchronously to mclk,
  and that the serial clock is far slower than mclk (a few mclk per phase).
*/

// Queue of fixed width and depth with valid and ready at both sides
module twe_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];   // Entry storage, no reset needed
  logic [PW-1:0]    wr_ptr;          // Next slot to fill
  logic [PW-1:0]    rd_ptr;          // Oldest slot
  logic [PW:0]      fill;            // Entries held
  logic             push;
  logic             pop;

  assign in_ready  = (fill != (PW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data  = store[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage write
  always_ff @(posedge mclk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      fill <= fill + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : twe_fifo

// Device side of the serial port
module twe_port
  import twe_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DFLT  // Shorten in simulation
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic dev_select,       // Select pin, active high
  input  wire logic serial_clock_in,  // Serial clock pin
  input  wire logic serial_in,        // Serial data pin
  output logic      serial_out,       // Data and ready/busy
  output logic      serial_out_oe     // High while driving serial_out
);

  // Two-stage synchronisers; first stages are read by the second only
  logic cs_m, cs_s, sclk_m, sclk_s, si_m, si_s;
  logic cs_prev;                       // Select one cycle ago
  logic sclk_prev;                     // Serial clock one cycle ago
  logic sclk_rise;                     // Serial clock rising edge
  logic cs_fall;                       // Select falling edge

  twe_state_t        state;            // Frame decoder state
  logic [3:0]        cnt;              // Bit counter in the current phase
  logic [7:0]        cmd_sr;           // Opcode and address shift
  logic [7:0]        cmd_next;         // Shift including this bit
  logic [WORD_W-1:0] data_sr;          // Write data shift
  logic [ADDR_W-1:0] addr;             // Command or read address
  logic              pend_v;           // A programming command is framed
  twe_kind_t         pend_kind;        // Its kind
  logic              prog_en;          // Programming allowed
  logic              stat_pend;        // Ready/busy is to be shown
  logic              rd_out;           // Read bit from flip-flop
  logic              start_take;       // Start bit taken this cycle
  logic              cmd_done;         // Last address bit taken
  logic              status_show;      // Output carries ready/busy
  logic              busy;             // Programming queued or running

  logic [WORD_W-1:0] mem [WORDS];      // The array itself
  logic              q_in_valid, q_in_ready, q_out_valid, q_out_ready;
  twe_prog_t         q_in, q_out;
  twe_prog_t         cur;              // Command being programmed
  logic              eng_active;       // Self-timed cycle running
  logic [CNT_W-1:0]  eng_cnt;          // Cycles left
  logic              commit;           // Array update this cycle

  // Pin synchronisers; nothing else reads the first stages
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {cs_m, cs_s, sclk_m, sclk_s, si_m, si_s} <= '0;
    end else begin
      cs_m   <= dev_select;
      cs_s   <= cs_m;
      sclk_m <= serial_clock_in;
      sclk_s <= sclk_m;
      si_m <= serial_in;
      si_s <= si_m;
    end
  end

  // Edge detection of the synchronised select and serial clock
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cs_prev   <= 1'b0;
      sclk_prev <= 1'b0;
    end else begin
      cs_prev   <= cs_s;
      sclk_prev <= sclk_s;
    end
  end

  assign sclk_rise  = sclk_s & ~sclk_prev;                             // RULE15
  assign cs_fall    = cs_prev & ~cs_s;                                 // RULE15
  assign busy       = eng_active | q_out_valid;
  // Starts are refused while busy, so status keeps being shown
  assign start_take = cs_s & sclk_rise & si_s & (state == ST_IDLE) & ~busy; // RULE10
  assign cmd_next   = {cmd_sr[6:0], si_s};                             // RULE1
  assign cmd_done   = cs_s & sclk_rise & (state == ST_CMD) & (cnt == CMD_LAST);

  // Frame decoder: start bit, opcode, address, data, read stream
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      cnt       <= '0;
      cmd_sr    <= '0;
      data_sr   <= '0;
      addr      <= '0;
      pend_v    <= 1'b0;
      pend_kind <= PK_WORD;
      rd_out    <= 1'b0;
    end else if (!cs_s) begin
      // Select low clears any half-framed command
      state  <= ST_IDLE;                                               // RULE6
      cnt    <= '0;
      pend_v <= 1'b0;
    end else if (sclk_rise) begin
      case (state)
        ST_IDLE: begin
          // Leading zeros are padding
          if (start_take) begin                                        // RULE10
            state <= ST_CMD;
            cnt   <= '0;
          end
        end
        ST_CMD: begin
          cmd_sr <= cmd_next;                                          // RULE1
          cnt    <= cnt + 1'b1;
          if (cnt == CMD_LAST) begin
            addr <= cmd_next[ADDR_W-1:0];
            cnt  <= '0;
            case (cmd_next[7:6])                                       // RULE11
              OPC_READ: begin
                state  <= ST_READ;
                rd_out <= 1'b0;                                        // RULE13
              end
              OPC_WRITE: begin
                state     <= ST_DATA;
                pend_kind <= PK_WORD;
              end
              OPC_ERASE: begin
                state     <= ST_DONE;
                pend_kind <= PK_ERASE;
                pend_v    <= 1'b1;
              end
              default: begin
                state <= ST_DONE;
                if (cmd_next[5:4] == EXT_BULK_WR) begin
                  state     <= ST_DATA;
                  pend_kind <= PK_ALL;
                end else if (cmd_next[5:4] == EXT_BULK_ER) begin
                  pend_kind <= PK_ERALL;
                  pend_v    <= 1'b1;
                end
              end
            endcase
          end
        end
        ST_DATA: begin
          data_sr <= {data_sr[WORD_W-2:0], si_s};                      // RULE8
          cnt     <= cnt + 1'b1;
          if (cnt == WORD_LAST) begin
            state  <= ST_DONE;
            pend_v <= 1'b1;
          end
        end
        ST_READ: begin
          // One bit per rise, msb first, rolling to the next word
          rd_out <= mem[addr][WORD_LAST - cnt];                        // RULE2 RULE13
          cnt    <= cnt + 1'b1;
          if (cnt == WORD_LAST) begin
            addr <= addr + 1'b1;                                       // RULE13
          end
        end
        ST_DONE: begin
          state <= ST_DONE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Program enable: cleared at reset, changed only by its commands
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prog_en <= 1'b0;                                                 // RULE12
    end else if (cmd_done && cmd_next[7:6] == OPC_EXT) begin
      if (cmd_next[5:4] == EXT_EN) begin
        prog_en <= 1'b1;                                               // RULE12
      end else if (cmd_next[5:4] == EXT_DIS) begin
        prog_en <= 1'b0;                                               // RULE12
      end
    end
  end

  // A framed programming command launches at select fall if allowed
  assign q_in_valid = cs_fall & pend_v & prog_en;                      // RULE12
  assign q_in       = '{kind: pend_kind, addr: addr, data: data_sr};

  // Status flag: set at launch, cleared by the next start bit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stat_pend <= 1'b0;
    end else if (q_in_valid && q_in_ready) begin
      stat_pend <= 1'b1;                                               // RULE3
    end else if (start_take) begin
      stat_pend <= 1'b0;                                               // RULE4
    end
  end

  // Shared output: status or read data, released while deselected
  assign status_show   = stat_pend & (state == ST_IDLE);              // RULE4
  assign serial_out    = status_show ? ~busy : rd_out;                 // RULE9 RULE14
  assign serial_out_oe = cs_s & (status_show | (state == ST_READ));    // RULE3 RULE5

  twe_fifo #(
    .WIDTH ($bits(twe_prog_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_queue (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_valid  (q_in_valid),
    .in_ready  (q_in_ready),
    .in_data   (q_in),
    .out_valid (q_out_valid),
    .out_ready (q_out_ready),
    .out_data  (q_out)
  );

  // Engine takes one command only when idle; starts are refused while busy, so the queue holds one at most
  assign q_out_ready = ~eng_active;
  assign commit      = eng_active & (eng_cnt == '0);

  // Self-timed programming counter
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      eng_active <= 1'b0;
      eng_cnt    <= '0;
      cur        <= '0;
    end else if (!eng_active && q_out_valid) begin
      eng_active <= 1'b1;
      eng_cnt    <= CNT_W'(PROG_CYCLES - 1);                           // RULE7
      cur        <= q_out;
    end else if (eng_active) begin
      eng_cnt <= eng_cnt - 1'b1;
      if (eng_cnt == '0) begin
        eng_active <= 1'b0;                                            // RULE7 RULE14
      end
    end
  end

  // Array words: each one updates at its own or a bulk commit
  for (genvar g = 0; g < WORDS; g++) begin : g_word
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        mem[g] <= ERASED_WORD;
      end else if (commit && (cur.kind == PK_ALL || cur.kind == PK_ERALL || cur.addr == ADDR_W'(g))) begin
        mem[g] <= (cur.kind == PK_ERASE || cur.kind == PK_ERALL) ? ERASED_WORD : cur.data;
      end
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_start;
    start_take;
  endsequence
  sequence s_read_cmd;
    cmd_done && cmd_next[7:6] == OPC_READ;
  endsequence

  release_desel_a: assert property (!cs_s |-> !serial_out_oe) // RULE5
    else $error("output driven while deselected");
  sample_start_a: assert property (s_start |=> state == ST_CMD && cnt == '0) // RULE1
    else $error("start bit not taken");
  zeros_ignored_a: assert property (state == ST_IDLE && cs_s && sclk_rise && !si_s |=> state == ST_IDLE) // RULE10
    else $error("zero left idle");
  dummy_bit_a: assert property (s_read_cmd |=> state == ST_READ && !serial_out && serial_out_oe) // RULE13
    else $error("dummy bit missing");
  read_bit_a: assert property (cs_s && sclk_rise && state == ST_READ && cs_prev // RULE2
    |=> serial_out == $past(mem[addr][WORD_LAST - cnt]))
    else $error("read bit mismatch");
  desel_reset_a: assert property (!cs_s |=> state == ST_IDLE && !pend_v) // RULE6
    else $error("decoder not reset");
  status_out_a: assert property (status_show && cs_s |-> serial_out_oe && serial_out == !busy) // RULE3 RULE14
    else $error("status not shown");
  start_clears_a: assert property (s_start ##1 !(q_in_valid && q_in_ready) |-> !stat_pend) // RULE4
    else $error("status not cleared");
  prog_time_a: assert property ($rose(eng_active) |-> eng_cnt == CNT_W'(PROG_CYCLES - 1)) // RULE7
    else $error("bad programming time");
  prog_end_a: assert property (commit |=> !eng_active) // RULE7
    else $error("cycle did not end");
  protect_a: assert property (cs_fall && !prog_en && !busy |=> !busy) // RULE12
    else $error("programming while disabled");
  busy_low_a: assert property (eng_active && cs_s && status_show |-> !serial_out) // RULE14
    else $error("ready while busy");

endmodule : twe_port

//--- pkg/twe_pkg.sv
/*
  Constants, types and field layouts shared by the three-wire serial memory port.
  Assumes a 20 MHz system clock; pins reach the block asynchronously.
*/
// How it works
// RULE1 - Sample serial input at each serial clock rise
// RULE2 - Read data changes at each serial clock rise
// RULE3 - Show ready/busy after select returns after programming
// RULE4 - Ready/busy stays until next start bit
// RULE5 - Output released while select is low
// RULE6 - Select low resets command decoding
// RULE7 - Programming cycle completes within 5 ms
// RULE8 - Host sends start, opcode, address, data
// RULE9 - One output carries read data and status
// RULE10 - Frame starts at first one; zeros ignored; ones are also ignored while busy
// RULE11 - Two-bit opcode, six-bit address, extended codes
// RULE12 - Programming blocked until enable; reads always work; a read frame is refused while busy
// RULE13 - Dummy zero, word msb first, auto increment
// RULE14 - Status low while busy, high when done
// RULE15 - Pins sampled by fast clock, edges detected
package twe_pkg;

  localparam int ADDR_W   = 6;              // Word address width
  localparam int WORD_W   = 16;             // Stored word width
  localparam int WORDS    = 64;             // Array depth
  localparam int FIFO_DEPTH = 16;           // Pending programming commands

  localparam logic [3:0] CMD_LAST  = 4'h7;  // Opcode plus address bits, less one
  localparam logic [3:0] WORD_LAST = 4'hF;  // Data bits, less one

  localparam logic [1:0] OPC_EXT   = 2'h0;  // Extended code follows
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_READ  = 2'h2;
  localparam logic [1:0] OPC_ERASE = 2'h3;
  localparam logic [1:0] EXT_DIS   = 2'h0;  // Program disable
  localparam logic [1:0] EXT_BULK_WR = 2'h1;  // Bulk write
  localparam logic [1:0] EXT_BULK_ER = 2'h2;  // Bulk erase
  localparam logic [1:0] EXT_EN    = 2'h3;  // Program enable

  localparam logic [WORD_W-1:0] ERASED_WORD = 16'hFFFF; // Erased and reset content

  // Programming time in its own unit, and the cycle count derived from it
  localparam int PROG_TIME_MS    = 5;
  localparam int MCLK_PERIOD_NS  = 50;
  localparam int PROG_CYCLES_DFLT = (PROG_TIME_MS * 1000000) / MCLK_PERIOD_NS; // Longest time: round down
  localparam int CNT_W           = 17;

  // Kinds of self-timed programming
  typedef enum logic [1:0] {
    PK_WORD  = 2'h0,
    PK_ALL   = 2'h1,
    PK_ERASE = 2'h2,
    PK_ERALL = 2'h3
  } twe_kind_t;

  // One programming command as it waits in the queue
  typedef struct packed {
    twe_kind_t          kind;
    logic [ADDR_W-1:0]  addr;
    logic [WORD_W-1:0]  data;
  } twe_prog_t;

  // Frame decoder states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CMD  = 5'h02,
    ST_DATA = 5'h04,
    ST_READ = 5'h08,
    ST_DONE = 5'h10
  } twe_state_t;

endpackage : twe_pkg

//--- sim/twe_host.sv
/*
  Controller model for the serial memory port: drives select, serial clock and serial input.
  Assumes the bench calls its tasks one at a time and that mclk runs at 20 MHz.
*/
module twe_host (
  input  wire logic mclk,            // Bench clock, pins change at its fall
  input  wire logic serial_out,      // Device data and status
  output logic      dev_select,      // Select, high while framing
  output logic      serial_clock_in, // Serial clock, still and low outside frames
  output logic      serial_in        // Serial data to the device
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pins idle low from time zero
  initial begin
    dev_select      = 1'b0;
    serial_clock_in = 1'b0;
    serial_in       = 1'b0;
  end

  // Wait whole mclk periods, landing at a falling edge
  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask : wait_n

  // Move select and give the synchronisers time to see it
  task automatic set_select(input logic s);
    dev_select = s;
    wait_n(4);
  endtask : set_select

  // One 500 ns clock: data settles while low, read bit is sampled well after the rise
  task automatic shift_bit(input logic b, output logic o);
    serial_in = b;
    wait_n(4);
    serial_clock_in = 1'b1;
    wait_n(4);
    serial_clock_in = 1'b0;
    wait_n(2);
    o = serial_out;
  endtask : shift_bit

  // Whole frame, msb first, with one leading zero as padding
  task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
    logic o;
    rx = '0;
    set_select(1'b1);
    shift_bit(1'b0, o);
    for (int i = n - 1; i >= 0; i--) begin
      shift_bit(tx[i], o);
      rx = {rx[62:0], o};
    end
    set_select(1'b0);
  endtask : frame
endmodule : twe_host

//--- sim/twe_port_bench.sv
/*
  Self-checking bench for the serial memory port, with the controller model as partner.
  Assumes the port and its package are compiled first; programming is shortened to 200 mclk.
*/
module twe_port_bench
  import twe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PROG = 200; // Stands in for the 5 ms programming time

  logic        mclk = 1'b0;  // 20 MHz
  logic        rst_n = 1'b0; // Held low at start
  logic        dev_select;
  logic        serial_clock_in;
  logic        serial_in;
  logic        serial_out;
  logic        serial_out_oe;
  logic        line_out;     // Output pin as the host sees it
  logic [63:0] rx;           // Bits seen during the last frame
  logic        dmy;          // Bit after the last address bit
  logic [15:0] w0;           // First word read
  logic [15:0] w1;           // Second word, next address
  int          n_mismatch = 0;
  int          samples_checked = 0;

  // Clock, half period 25 ns
  always #25 mclk = ~mclk;

  // A released line shows the inverse of the last value, so an early release corrupts reads
  assign line_out = serial_out_oe ? serial_out : ~serial_out;

  twe_port #(.PROG_CYCLES(PROG)) u_twe_port (
    .mclk            (mclk),
    .rst_n           (rst_n),
    .dev_select      (dev_select),
    .serial_clock_in (serial_clock_in),
    .serial_in       (serial_in),
    .serial_out      (serial_out),
    .serial_out_oe   (serial_out_oe)
  );

  twe_host u_twe_host (
    .mclk            (mclk),
    .serial_out      (line_out),
    .dev_select      (dev_select),
    .serial_clock_in (serial_clock_in),
    .serial_in       (serial_in)
  );

  // Verdict and end of run, reached from the main sequence or a spent wait
  task automatic test_done();
    $display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  // Compare one value, four-state exact
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Start bit, opcode and address
  function automatic logic [8:0] cmd(input logic [1:0] op, input logic [5:0] a);
    return {1'b1, op, a};
  endfunction : cmd

  // Short command with no data
  task automatic send9(input logic [1:0] op, input logic [5:0] a);
    u_twe_host.frame({55'h0, cmd(op, a)}, 9, rx);
  endtask : send9

  // Command followed by one data word
  task automatic send25(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d);
    u_twe_host.frame({39'h0, cmd(op, a), d}, 25, rx);
  endtask : send25

  // Read two successive words; select held so the address steps
  task automatic read2(input logic [5:0] a);
    u_twe_host.frame({23'h0, cmd(OPC_READ, a), 32'h0}, 41, rx);
    dmy = rx[32];
    w0  = rx[31:16];
    w1  = rx[15:0];
  endtask : read2

  // Select high after programming: busy low first, then ready high that stays put
  task automatic wait_ready(input string what);
    logic saw_busy;
    int   i;
    saw_busy = 1'b0;
    u_twe_host.set_select(1'b1);
    for (i = 0; i < PROG + 100 && !(serial_out_oe === 1'b1 && serial_out === 1'b1); i++) begin
      if (serial_out_oe === 1'b1 && serial_out === 1'b0)
        saw_busy = 1'b1;
      @(negedge mclk);
    end
    if (i >= PROG + 100) begin
      n_mismatch++;
      $display("MISMATCH %s ready expected 1 seen 0", what);
      test_done();
    end
    check({what, " busy"}, 16'h1, {15'h0, saw_busy});
    repeat (20) @(negedge mclk);
    check({what, " ready hold"}, 16'h1, {15'h0, serial_out & serial_out_oe});
    u_twe_host.set_select(1'b0);
    check({what, " release"}, 16'h0, {15'h0, serial_out_oe});
  endtask : wait_ready

  // Fresh part reads erased words, dummy zero first
  task automatic t_power_read();
    check("idle oe", 16'h0, {15'h0, serial_out_oe});
    read2(6'h05);
    check("dummy", 16'h0, {15'h0, dmy});
    check("read 5", 16'hFFFF, w0);
    check("read 6", 16'hFFFF, w1);
  endtask : t_power_read

  // Writing before enable must leave the array alone
  task automatic t_locked();
    send25(OPC_WRITE, 6'h03, 16'h1234);
    read2(6'h03);
    check("locked write", 16'hFFFF, w0);
  endtask : t_locked

  // Enable, write the top word, read across the wrap to word 0
  task automatic t_write_wrap();
    send9(OPC_EXT, {EXT_EN, 4'h0});
    send25(OPC_WRITE, 6'h3F, 16'hA5C3);
    wait_ready("write");
    read2(6'h3F);
    check("write 63", 16'hA5C3, w0);
    check("wrap 0", 16'hFFFF, w1);
  endtask : t_write_wrap

  // Bulk write, single erase, bulk erase
  task automatic t_bulk();
    send25(OPC_EXT, {EXT_BULK_WR, 4'h0}, 16'h5A5A);
    wait_ready("bulk write");
    send9(OPC_ERASE, 6'h0A);
    wait_ready("erase");
    read2(6'h09);
    check("bulk 9", 16'h5A5A, w0);
    check("erased 10", 16'hFFFF, w1);
    send9(OPC_EXT, {EXT_BULK_ER, 4'h0});
    wait_ready("bulk erase");
    read2(6'h3E);
    check("erall 62", 16'hFFFF, w0);
    check("erall 63", 16'hFFFF, w1);
  endtask : t_bulk

  // After disable, writes are ignored again while reads still work
  task automatic t_disable();
    send9(OPC_EXT, {EXT_DIS, 4'h0});
    send25(OPC_WRITE, 6'h09, 16'h1111);
    read2(6'h09);
    check("disabled write", 16'hFFFF, w0);
  endtask : t_disable

  // Main sequence
  initial begin
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    t_power_read();
    t_locked();
    t_write_wrap();
    t_bulk();
    t_disable();
    test_done();
  end
endmodule : twe_port_bench
